// File: tmsw_regs.svh
// Register offsets, field positions, reset values and timing counts of the switch control bank
`ifndef TMSW_REGS_SVH
`define TMSW_REGS_SVH
`define TMSW_OFS_CHSEL 8'h00
`define TMSW_OFS_OUTCTL 8'h01
`define TMSW_OFS_INCTL 8'h02
`define TMSW_OFS_TERM 8'h03
`define TMSW_OFS_AUX 8'h04
`define TMSW_OFS_HPW 8'h05
`define TMSW_RST_CHSEL 8'h00
`define TMSW_RST_OUTCTL 8'h07
`define TMSW_RST_INCTL 8'h02
`define TMSW_RST_TERM 8'h0f
`define TMSW_RST_AUX 8'h07
`define TMSW_RST_HPW 8'h05
`define TMSW_MASK_CHSEL 8'h07
`define TMSW_MASK_OUTCTL 8'h0f
`define TMSW_MASK_INCTL 8'h03
`define TMSW_MASK_TERM 8'hff
`define TMSW_MASK_AUX 8'h07
`define TMSW_MASK_HPW 8'hff
`define TMSW_BIT_CHANNEL_SOURCE_SEL 2
`define TMSW_BIT_OE_SRC 3
`define TMSW_BIT_OE 2
`define TMSW_BIT_OCL 1
`define TMSW_BIT_OTO 0
`define TMSW_BIT_EQ 1
`define TMSW_BIT_POL 0
`define TMSW_BIT_DDC 1
`define TMSW_BIT_CEC 0
`define TMSW_TERM_AUTO 4'h0
`define TMSW_TERM_MANUAL 4'hf
`define TMSW_ADDR_HI 5'h12
`define TMSW_HP_STEP_MS 24
`define TMSW_CLK_HZ 100000000
`define TMSW_HP_STEP_CYC (`TMSW_HP_STEP_MS * (`TMSW_CLK_HZ / 1000))
`endif

// File: tmsw_pkg.sv
// Types shared by the switch control bank
package tmsw_pkg;
   // Decoded settings driven toward the analog switch
   typedef struct packed {
      logic [1:0] channel; // Active input, 0=A .. 3=D
      logic out_en;
      logic out_current_level; // 0: 10 mA, 1: 20 mA
      logic out_termination_on;
      logic eq_boost_choice; // 0: 6 dB, 1: 18 dB
      logic input_polarity_invert;
      logic [3:0] in_term_on; // Per input termination, bit0=A
      logic ddc_buffer_on;
      logic cec_buffer_on;
   } tmsw_ctrl_t;
   // Serial slave states
   typedef enum logic [2:0] {
      TMSW_IDLE, TMSW_DEVADR, TMSW_ACK, TMSW_REGADR, TMSW_WDATA, TMSW_RDATA, TMSW_RACK
   } tmsw_state_t;
endpackage : tmsw_pkg

// File: tmsw_ctrl.sv
// Two-wire slave register bank and control decode for a four-to-one link switch
`timescale 1ns/1ns
`include "tmsw_regs.svh"
module tmsw_ctrl
   import tmsw_pkg::*;
#(
   parameter int unsigned HP_STEP_CYC = `TMSW_HP_STEP_CYC
)
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_reset_pin_n,
   input wire logic [1:0] i_addr_strap,
   input wire logic [1:0] i_sel_pins,
   input wire logic i_out_enable_pin,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda_oe,
   output logic o_sda_out,
   output tmsw_ctrl_t o_ctrl,
   output logic o_hotplug_low
);
   // Register storage
   logic [7:0] chsel_ff, outctl_ff, inctl_ff, term_ff, aux_ff, hpw_ff;
   // Serial line sampling for edge detection
   logic scl_ff, sda_ff;
   // Slave state
   tmsw_state_t state_ff, nxt_state;
   logic [7:0] shift_ff; // Incoming / outgoing byte
   logic [3:0] bit_cnt_ff; // Bits moved in the current byte
   logic [7:0] ptr_ff; // Register pointer
   logic rnw_ff; // Current transfer is a read
   logic addr_phase_ff; // Next written byte is the pointer
   logic sda_oe_ff, sda_out_ff;
   // Outputs and hot-plug timing
   tmsw_ctrl_t ctrl_ff;
   logic [1:0] prev_chan_ff;
   logic chan_valid_ff; // Blocks a pulse on the first cycle after reset
   logic [7:0] hp_steps_ff; // Remaining pulse steps
   logic [31:0] hp_cyc_ff; // Cycles left in the current step
   logic hp_low_ff;

   // Combined reset: system reset or the reset pin
   wire rst = i_sys_rst | ~i_reset_pin_n;

   // Line events
   wire scl_rise = i_scl & ~scl_ff;
   wire scl_fall = ~i_scl & scl_ff;
   wire start_cond = scl_ff & i_scl & sda_ff & ~i_sda;
   wire stop_cond = scl_ff & i_scl & ~sda_ff & i_sda;
   wire [6:0] my_addr = {`TMSW_ADDR_HI, i_addr_strap};
   wire [7:0] shift_in = {shift_ff[6:0], i_sda};

   // Masked read value for an offset
   function automatic logic [7:0] rd_val(input logic [7:0] ofs, input logic [7:0] c0,
      input logic [7:0] c1, input logic [7:0] c2, input logic [7:0] c3,
      input logic [7:0] c4, input logic [7:0] c5);
      case (ofs)
         `TMSW_OFS_CHSEL: rd_val = c0 & `TMSW_MASK_CHSEL;
         `TMSW_OFS_OUTCTL: rd_val = c1 & `TMSW_MASK_OUTCTL;
         `TMSW_OFS_INCTL: rd_val = c2 & `TMSW_MASK_INCTL;
         `TMSW_OFS_TERM: rd_val = c3 & `TMSW_MASK_TERM;
         `TMSW_OFS_AUX: rd_val = c4 & `TMSW_MASK_AUX;
         `TMSW_OFS_HPW: rd_val = c5 & `TMSW_MASK_HPW;
         default: rd_val = 8'h00;
      endcase
   endfunction : rd_val

   wire [7:0] rd_data = rd_val(ptr_ff, chsel_ff, outctl_ff, inctl_ff, term_ff, aux_ff, hpw_ff);
   // A data byte completes on this rising clock edge
   wire byte_done = scl_rise & (bit_cnt_ff == 4'h7);
   wire wr_stb = byte_done & (state_ff == TMSW_WDATA) & ~addr_phase_ff;

   // Next state of the slave
   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         TMSW_IDLE: nxt_state = state_ff;
         TMSW_DEVADR:
            if (byte_done)
               nxt_state = (shift_in[7:1] == my_addr) ? TMSW_ACK : TMSW_IDLE;
         TMSW_ACK:
            if (scl_fall & sda_oe_ff)
               nxt_state = rnw_ff ? TMSW_RDATA : TMSW_WDATA;
         TMSW_WDATA:
            if (byte_done)
               nxt_state = TMSW_ACK;
         TMSW_REGADR: nxt_state = TMSW_WDATA;
         TMSW_RDATA:
            if (byte_done)
               nxt_state = TMSW_RACK;
         TMSW_RACK:
            if (scl_rise)
               nxt_state = i_sda ? TMSW_IDLE : TMSW_RDATA;
         default: nxt_state = TMSW_IDLE;
      endcase
      if (start_cond)
         nxt_state = TMSW_DEVADR;
      else if (stop_cond)
         nxt_state = TMSW_IDLE;
   end

   // Line sampling
   always_ff @(posedge i_mclk)
   begin
      scl_ff <= rst ? 1'b1 : i_scl;
      sda_ff <= rst ? 1'b1 : i_sda;
   end

   // Slave sequencing: shifting, pointer and acknowledge drive
   always_ff @(posedge i_mclk)
   begin
      if (rst)
      begin
         state_ff <= TMSW_IDLE;
         shift_ff <= 8'h00;
         bit_cnt_ff <= 4'h0;
         ptr_ff <= 8'h00;
         rnw_ff <= 1'b0;
         addr_phase_ff <= 1'b0;
         sda_oe_ff <= 1'b0;
         sda_out_ff <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         if (start_cond | stop_cond)
         begin
            bit_cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
         end
         else if (scl_rise & (state_ff != TMSW_ACK) & (state_ff != TMSW_RACK))
         begin
            // Sample one bit, MSB first; during a read the byte moves out on falling
            // edges only, so shifting here as well would skip every other bit
            if (state_ff != TMSW_RDATA)
               shift_ff <= shift_in;
            bit_cnt_ff <= byte_done ? 4'h0 : bit_cnt_ff + 4'h1;
            if (byte_done & (state_ff == TMSW_DEVADR))
            begin
               rnw_ff <= i_sda;
               addr_phase_ff <= ~i_sda;
            end
            if (byte_done & (state_ff == TMSW_WDATA))
            begin
               // First written byte is the pointer, later bytes auto-increment it
               if (addr_phase_ff)
                  ptr_ff <= shift_in;
               else
                  ptr_ff <= ptr_ff + 8'h01;
               addr_phase_ff <= 1'b0;
            end
            if (byte_done & (state_ff == TMSW_RDATA))
               ptr_ff <= ptr_ff + 8'h01;
         end
         else if (scl_fall)
         begin
            // Drive acknowledge or read data after the falling edge
            if (state_ff == TMSW_ACK & ~sda_oe_ff)
            begin
               sda_oe_ff <= 1'b1;
               sda_out_ff <= 1'b0;
            end
            // Load a fresh read byte only at its first bit, after an acknowledge
            else if ((nxt_state == TMSW_RDATA) & (bit_cnt_ff == 4'h0))
            begin
               sda_oe_ff <= ~rd_data[7];
               sda_out_ff <= 1'b0;
               shift_ff <= {rd_data[6:0], 1'b1};
            end
            else if (state_ff == TMSW_RDATA & bit_cnt_ff != 4'h0)
            begin
               sda_oe_ff <= ~shift_ff[7];
               shift_ff <= {shift_ff[6:0], 1'b1};
            end
            else
               sda_oe_ff <= 1'b0;
         end
      end
   end

   // Register writes; reserved bits keep what is written, unused bits are dropped
   always_ff @(posedge i_mclk)
   begin
      if (rst)
      begin
         chsel_ff <= `TMSW_RST_CHSEL;
         outctl_ff <= `TMSW_RST_OUTCTL;
         inctl_ff <= `TMSW_RST_INCTL;
         term_ff <= `TMSW_RST_TERM;
         aux_ff <= `TMSW_RST_AUX;
         hpw_ff <= `TMSW_RST_HPW;
      end
      else if (wr_stb)
      begin
         case (ptr_ff)
            `TMSW_OFS_CHSEL: chsel_ff <= shift_in & `TMSW_MASK_CHSEL;
            `TMSW_OFS_OUTCTL: outctl_ff <= shift_in & `TMSW_MASK_OUTCTL;
            `TMSW_OFS_INCTL: inctl_ff <= shift_in & `TMSW_MASK_INCTL;
            `TMSW_OFS_TERM: term_ff <= shift_in;
            `TMSW_OFS_AUX: aux_ff <= shift_in & `TMSW_MASK_AUX;
            `TMSW_OFS_HPW: hpw_ff <= shift_in;
            default: chsel_ff <= chsel_ff;
         endcase
      end
   end

   // Control decode
   wire [1:0] chan = chsel_ff[`TMSW_BIT_CHANNEL_SOURCE_SEL] ? chsel_ff[1:0] : i_sel_pins;
   wire oe = outctl_ff[`TMSW_BIT_OE_SRC] ? outctl_ff[`TMSW_BIT_OE] : i_out_enable_pin;
   wire term_manual = (term_ff[7:4] == `TMSW_TERM_MANUAL);
   wire [3:0] term_auto = 4'h1 << chan;
   wire [3:0] term_on = term_manual ? term_ff[3:0] : term_auto;
   tmsw_ctrl_t nxt_ctrl;
   assign nxt_ctrl = '{
      channel: chan,
      out_en: oe,
      out_current_level: outctl_ff[`TMSW_BIT_OCL],
      out_termination_on: outctl_ff[`TMSW_BIT_OTO],
      eq_boost_choice: inctl_ff[`TMSW_BIT_EQ],
      input_polarity_invert: inctl_ff[`TMSW_BIT_POL],
      in_term_on: term_on,
      ddc_buffer_on: aux_ff[`TMSW_BIT_DDC],
      cec_buffer_on: aux_ff[`TMSW_BIT_CEC]
   };

   // Registered control outputs
   always_ff @(posedge i_mclk)
   begin
      if (rst)
         ctrl_ff <= '0;
      else
         ctrl_ff <= nxt_ctrl;
   end

   // Hot-plug pulse: count of steps, each HP_STEP_CYC cycles long
   // A new switch during a running pulse restarts it from the full width
   always_ff @(posedge i_mclk)
   begin
      if (rst)
      begin
         prev_chan_ff <= 2'h0;
         chan_valid_ff <= 1'b0;
         hp_steps_ff <= 8'h00;
         hp_cyc_ff <= 32'h0;
         hp_low_ff <= 1'b0;
      end
      else
      begin
         prev_chan_ff <= chan;
         chan_valid_ff <= 1'b1;
         if (chan_valid_ff & (chan != prev_chan_ff) & (hpw_ff != 8'h00))
         begin
            hp_steps_ff <= hpw_ff;
            hp_cyc_ff <= HP_STEP_CYC - 1;
            hp_low_ff <= 1'b1;
         end
         else if (hp_low_ff)
         begin
            if (hp_cyc_ff != 32'h0)
               hp_cyc_ff <= hp_cyc_ff - 32'h1;
            else if (hp_steps_ff == 8'h01)
            begin
               hp_steps_ff <= 8'h00;
               hp_low_ff <= 1'b0;
            end
            else
            begin
               hp_steps_ff <= hp_steps_ff - 8'h01;
               hp_cyc_ff <= HP_STEP_CYC - 1;
            end
         end
      end
   end

   // Every output comes straight from a flip-flop
   assign o_sda_oe = sda_oe_ff;
   assign o_sda_out = sda_out_ff;
   assign o_ctrl = ctrl_ff;
   assign o_hotplug_low = hp_low_ff;
endmodule : tmsw_ctrl

// File: tmsw_checker.sv
// Port-level assertions for the switch control bank
`timescale 1ns/1ns
module tmsw_checker
   import tmsw_pkg::*;
#(
   parameter int unsigned HP_STEP_CYC = 10
)
(
   input wire logic i_mclk,
   input wire logic i_sys_rst,
   input wire logic i_reset_pin_n,
   input wire logic [1:0] i_sel_pins,
   input wire logic i_out_enable_pin,
   input wire logic i_scl,
   input wire logic o_sda_oe,
   input wire logic o_sda_out,
   input wire tmsw_ctrl_t o_ctrl,
   input wire logic o_hotplug_low
);
   wire logic rst = i_sys_rst | ~i_reset_pin_n; // Either reset source
   logic [3:0] since_ff; // Cycles since reset release, saturating
   logic [31:0] hi_ff; // Length of the running hot-plug pulse
   // Helper counters
   always_ff @(posedge i_mclk)
   begin
      since_ff <= rst ? 4'h0 : (since_ff == 4'hf ? since_ff : since_ff + 4'h1);
      hi_ff <= (rst | ~o_hotplug_low) ? 32'h0 : hi_ff + 32'h1;
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (rst);
   a_rst_defaults: assert property (($fell(i_sys_rst) || $rose(i_reset_pin_n)) |-> ##2
      (o_ctrl.channel == i_sel_pins && o_ctrl.out_en == i_out_enable_pin
      && o_ctrl.out_current_level && o_ctrl.out_termination_on && o_ctrl.eq_boost_choice
      && !o_ctrl.input_polarity_invert && o_ctrl.in_term_on == 4'h1 << o_ctrl.channel
      && o_ctrl.ddc_buffer_on && o_ctrl.cec_buffer_on)) else $error("bad defaults");
   a_hp_quiet_rst: assert property ($fell(i_sys_rst) |-> (!o_hotplug_low)[*4])
      else $error("pulse after reset");
   a_hp_on_change: assert property (since_ff > 4'h4 && $changed(o_ctrl.channel)
      |-> ##[0:2] o_hotplug_low) else $error("no pulse on switch");
   a_hp_has_cause: assert property (since_ff > 4'h4 && $rose(o_hotplug_low)
      |-> o_ctrl.channel != $past(o_ctrl.channel, 2)) else $error("pulse without switch");
   a_hp_min_len: assert property ($fell(o_hotplug_low) |-> hi_ff >= HP_STEP_CYC)
      else $error("pulse too short");
   a_hp_max_len: assert property (hi_ff <= 255 * HP_STEP_CYC + 1)
      else $error("pulse too long");
   a_sda_open_drain: assert property (o_sda_out == 1'b0)
      else $error("data line driven high");
   a_ack_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl && !$past(i_scl))
      else $error("data changed with clock high");
   c_pulse: cover property ($rose(o_hotplug_low));
   c_ack: cover property ($rose(o_sda_oe));
   c_switch: cover property ($changed(o_ctrl.channel));
endmodule : tmsw_checker
bind tmsw_ctrl tmsw_checker #(.HP_STEP_CYC(HP_STEP_CYC)) chk (.i_mclk(i_mclk),
   .i_sys_rst(i_sys_rst), .i_reset_pin_n(i_reset_pin_n), .i_sel_pins(i_sel_pins),
   .i_out_enable_pin(i_out_enable_pin), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
   .o_sda_out(o_sda_out), .o_ctrl(o_ctrl), .o_hotplug_low(o_hotplug_low));

// File: tmsw_host_model.sv
// Two-wire bus master that programs the switch registers
`timescale 1ns/1ns
module tmsw_host_model
(
   input wire logic i_mclk,
   input wire logic i_sda_wire,
   output logic o_scl,
   output logic o_sda
);
   localparam int Q = 4; // Clock cycles per quarter bit, keeps lines stable around edges
   logic o_scl_i = 1'b1; // Clock idles high between frames
   logic o_sda_i = 1'b1; // A 1 releases the pulled-up data line
   assign o_scl = o_scl_i;
   assign o_sda = o_sda_i;
   // Step whole cycles, then move just past the edge
   task automatic tick();
      repeat (Q) @(posedge i_mclk);
      #1;
   endtask : tick
   // One bit: data set while clock low, line sampled while clock high
   task automatic bit_io(input logic b, output logic r);
      o_sda_i = b;
      tick();
      o_scl_i = 1'b1;
      tick();
      r = i_sda_wire;
      tick();
      o_scl_i = 1'b0;
      tick();
   endtask : bit_io
   // Byte out MSB first, then the acknowledge bit
   task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(a, k);
   endtask : xfer
   // Start or stop edge on data while clock is high
   task automatic edge_cond(input logic first, input logic last);
      o_sda_i = first;
      tick();
      o_scl_i = 1'b1;
      tick();
      o_sda_i = last;
      tick();
   endtask : edge_cond
   // Pointer write then data write, or repeated start and one read ended by a NACK
   task automatic access(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] dat,
      input logic rd_en, output logic [7:0] rdat, output logic ok);
      logic [7:0] q;
      logic k0, k1, k2, k3;
      edge_cond(1'b1, 1'b0);
      o_scl_i = 1'b0;
      tick();
      xfer({dev, 1'b0}, 1'b1, q, k0);
      xfer(ofs, 1'b1, q, k1);
      k3 = 1'b0;
      if (rd_en)
      begin
         edge_cond(1'b1, 1'b0);
         o_scl_i = 1'b0;
         tick();
         xfer({dev, 1'b1}, 1'b1, q, k2);
         xfer(8'hff, 1'b1, rdat, k3);
      end
      else
         xfer(dat, 1'b1, rdat, k2);
      edge_cond(1'b0, 1'b1);
      ok = ~(k0 | k1 | k2);
   endtask : access
endmodule : tmsw_host_model

// File: tb.sv
// Self-checking bench for the switch control bank
`timescale 1ns/1ns
module tb
   import tmsw_pkg::*;
;
   localparam logic [7:0] DFLT [0:5] = '{8'h00, 8'h07, 8'h02, 8'h0f, 8'h07, 8'h05};
   logic clk, sda_oe, sda_out, hp, ok, scl, host_sda;
   logic rst = 1'b1;
   logic rst_n = 1'b1;
   logic pin_en = 1'b1;
   logic [1:0] strap = 2'h1;
   logic [1:0] pins = 2'h3;
   logic [7:0] rd;
   logic [7:0] sh [0:5] = DFLT; // Expected register contents
   tmsw_ctrl_t ctrl;
   int fail_count = 0;
   int num_checks = 0;
   int cyc = 0;
   int n;
   wire logic sda = host_sda & ~sda_oe; // Pulled-up wire
   // Rows: offset, written value, read-back value
   logic [23:0] rows [0:15] = '{24'h01_f0_00, 24'h01_0b_0b, 24'h01_0c_0c, 24'h02_fd_01,
      24'h02_02_02, 24'h03_f5_f5, 24'h03_f8_f8, 24'h03_f0_f0, 24'h03_0a_0a, 24'h04_f8_00,
      24'h04_06_06, 24'h00_04_04, 24'h00_05_05, 24'h00_ff_07, 24'h00_06_06, 24'h08_55_00};
   tmsw_ctrl #(.HP_STEP_CYC(10)) uut (.i_mclk(clk), .i_sys_rst(rst), .i_reset_pin_n(rst_n),
      .i_addr_strap(strap), .i_sel_pins(pins), .i_out_enable_pin(pin_en), .i_scl(scl),
      .i_sda(sda), .o_sda_oe(sda_oe), .o_sda_out(sda_out), .o_ctrl(ctrl), .o_hotplug_low(hp));
   tmsw_host_model host (.i_mclk(clk), .i_sda_wire(sda), .o_scl(scl), .o_sda(host_sda));
   // Clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (cyc == 60000)
      begin
         fail_count = fail_count + 1;
         close_out();
      end
   end
   // Decoded outputs expected from the shadow registers and pins
   function automatic tmsw_ctrl_t exp_ctrl();
      tmsw_ctrl_t c;
      c.channel = sh[0][2] ? sh[0][1:0] : pins;
      c.out_en = sh[1][3] ? sh[1][2] : pin_en;
      c.out_current_level = sh[1][1];
      c.out_termination_on = sh[1][0];
      c.eq_boost_choice = sh[2][1];
      c.input_polarity_invert = sh[2][0];
      c.in_term_on = (sh[3][7:4] == 4'hf) ? sh[3][3:0] : 4'h1 << c.channel;
      c.ddc_buffer_on = sh[4][1];
      c.cec_buffer_on = sh[4][0];
      return c;
   endfunction : exp_ctrl
   // Byte or flag comparison
   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
         fail_count = fail_count + 1;
         $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
      end
   endtask : chk_val
   // Decoded control comparison
   task automatic chk_ctrl(input tmsw_ctrl_t got);
      num_checks = num_checks + 1;
      if (got !== exp_ctrl())
      begin
         fail_count = fail_count + 1;
         $display("unexpected at %0t: control %h, wanted %h", $time, got, exp_ctrl());
      end
   endtask : chk_ctrl
   // Verdict and end of run
   task automatic close_out();
      $display("checks %0d, mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      repeat (4) @(posedge clk);
      #1 chk_ctrl(ctrl);
      for (int i = 0; i < 6; i++)
      begin
         host.access(7'h49, i[7:0], 8'h00, 1'b1, rd, ok);
         chk_val(rd, sh[i]);
      end
      foreach (rows[r])
      begin
         host.access(7'h49, rows[r][23:16], rows[r][15:8], 1'b0, rd, ok);
         chk_val({7'h0, ok}, 8'h01);
         host.access(7'h49, rows[r][23:16], 8'h00, 1'b1, rd, ok);
         chk_val(rd, rows[r][7:0]);
         if (rows[r][23:16] < 8'h06)
            sh[rows[r][23:16]] = rows[r][7:0];
         chk_ctrl(ctrl);
      end
      // Pin sourcing and a short programmed hot-plug pulse
      host.access(7'h49, 8'h00, 8'h00, 1'b0, rd, ok);
      host.access(7'h49, 8'h05, 8'h02, 1'b0, rd, ok);
      sh[0] = 8'h00;
      pins = 2'h1;
      n = 0;
      repeat (40)
      begin
         @(posedge clk);
         #1 n = n + int'(hp === 1'b1);
      end
      chk_val(n[7:0], 8'h14);
      chk_ctrl(ctrl);
      // Address straps
      host.access(7'h4a, 8'h04, 8'h00, 1'b0, rd, ok);
      chk_val({7'h0, ok}, 8'h00);
      strap = 2'h2;
      host.access(7'h4a, 8'h04, 8'h00, 1'b1, rd, ok);
      chk_val(rd, sh[4]);
      // Reset pin in mid-run
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      pin_en = 1'b0;
      sh = DFLT;
      repeat (4) @(posedge clk);
      #1 chk_ctrl(ctrl);
      host.access(7'h4a, 8'h05, 8'h00, 1'b1, rd, ok);
      chk_val(rd, 8'h05);
      close_out();
   end
endmodule : tb
